/* File: logic/lre_pkg.sv */
// Constants, types and helpers for the long term predictor and pulse encoder
package lre_pkg;
  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam int DW        = 16;   // Sample width
  localparam int ACC_W     = 44;   // Accumulator width
  localparam int FRAME_LEN = 160;  // Samples per frame
  localparam int SUB_LEN   = 40;   // Samples per sub-segment
  localparam int SUB_CNT   = 4;    // Sub-segments per frame
  localparam int HIST_LEN  = 120;  // Reconstructed history depth
  localparam int LAG_MIN   = 40;   // Shortest lag
  localparam int LAG_MAX   = 120;  // Longest lag
  localparam int TAPS      = 11;   // Weighting filter length
  localparam int TAP_MID   = 5;    // Centre tap
  localparam int H_SHIFT   = 13;   // Tap scaling
  localparam int GRIDS     = 4;    // Candidate grids
  localparam int DECIM     = 3;    // Grid stride
  localparam int PULSES    = 13;   // Pulses per grid
  localparam int Q15       = 15;   // Fraction bits
  localparam int PCODE_W   = 3;    // Pulse code width
  localparam logic signed [DW-1:0] SMP_MAX = 16'sh7FFF;
  localparam logic signed [DW-1:0] SMP_MIN = 16'sh8000;
  // ----------------------------------------------------------------
  // Tables
  // ----------------------------------------------------------------
  localparam logic signed [DW-1:0] H_TAB [TAPS] = '{-16'sd134, -16'sd374, 16'sd0, 16'sd2054,
    16'sd5741, 16'sd8192, 16'sd5741, 16'sd2054, 16'sd0, -16'sd374, -16'sd134};
  localparam int GDL_DEN = 10;                       // Thresholds in tenths
  localparam int GDL_NUM [3] = '{2, 5, 8};           // 0.2, 0.5, 0.8
  localparam logic signed [DW:0] QLB_TAB [4] = '{17'sd3277, 17'sd11469, 17'sd21299, 17'sd32767};
  localparam int PLS_BASE  = -28672; // Code 0 level
  localparam int PLS_STEP  = 8192;   // Level spacing
  localparam int PLS_SCALE = 4;      // Q15 over step
  localparam int PLS_MID   = 4;      // First non-negative code
  localparam int XM_LIN    = 16;     // Codes on the linear segment
  localparam int XM_LSH    = 5;      // Linear interval is 32 wide
  localparam int XM_SEG    = 8;      // Codes per octave
  localparam int XM_EXP0   = 9;      // First octave exponent
  localparam int XM_EXPN   = 14;     // Last octave exponent
  localparam int XM_TOP    = 32767;  // Largest block maximum
  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {ST_LOAD, ST_CORR, ST_ENER, ST_GAIN, ST_PRED, ST_WGT,
                            ST_GRID, ST_XMAX, ST_QNT, ST_REC, ST_OUT} lre_state_e;
  // Clamp to sample range
  function automatic logic signed [DW-1:0] lre_sat(input logic signed [ACC_W-1:0] v);
    if (v > ACC_W'(SMP_MAX)) return SMP_MAX;
    if (v < ACC_W'(SMP_MIN)) return SMP_MIN;
    return v[DW-1:0];
  endfunction : lre_sat
endpackage : lre_pkg

/* File: logic/lre_adaptive_pulse_quantizer_quant.sv */
// Block maximum log coder and pulse quantiser, combinational
`timescale 1ns/1ps
module lre_adaptive_pulse_quantizer_quant (
  input  wire logic        [lre_pkg::DW-1:0]      xmax,  // Block maximum magnitude
  input  wire logic signed [lre_pkg::DW-1:0]      smp,   // Selected pulse sample
  output logic             [5:0]                  xmaxc, // Log code of maximum
  output logic             [lre_pkg::DW-1:0]      xmaxp, // Decoded maximum
  output logic             [lre_pkg::PCODE_W-1:0] pcode, // Pulse code
  output logic signed      [lre_pkg::DW-1:0]      pdec   // Decoded pulse
);
  int code, p, lvl;               // Working values
  logic signed [2*lre_pkg::DW+1:0] dprod; // Denormalise product
  // ----------------------------------------------------------------
  // Block maximum coding and its upper interval limit
  // ----------------------------------------------------------------
  always_comb begin
    code = int'(xmax) >> lre_pkg::XM_LSH;
    p = lre_pkg::XM_EXP0;
    // Octave segments double in width every eight codes
    for (int e = lre_pkg::XM_EXP0; e <= lre_pkg::XM_EXPN; e++) begin
      if (int'(xmax) >= (1 << e)) begin
        code = lre_pkg::XM_LIN + lre_pkg::XM_SEG * (e - lre_pkg::XM_EXP0)
             + ((int'(xmax) - (1 << e)) >> (e - 3));
      end
    end
    if (code < lre_pkg::XM_LIN) begin
      lvl = ((code + 1) << lre_pkg::XM_LSH) - 1;
    end else begin
      p = lre_pkg::XM_EXP0 + ((code - lre_pkg::XM_LIN) / lre_pkg::XM_SEG);
      lvl = (1 << p) + (((code % lre_pkg::XM_SEG) + 1) << (p - 3)) - 1;
    end
    xmaxc = 6'(code);
    xmaxp = lre_pkg::DW'(lvl);
  end
  // ----------------------------------------------------------------
  // Pulse code: compare 4*x against (c-4)*x'max, no divider needed
  // ----------------------------------------------------------------
  always_comb begin
    pcode = '0;
    for (int c = 1; c < (1 << lre_pkg::PCODE_W); c++) begin
      if (lre_pkg::PLS_SCALE * int'(smp) >= (c - lre_pkg::PLS_MID) * int'(xmaxp)) begin
        pcode = lre_pkg::PCODE_W'(c);
      end
    end
    dprod = 34'(lre_pkg::PLS_BASE + lre_pkg::PLS_STEP * int'(pcode)) * $signed({18'h0, xmaxp});
    pdec = lre_pkg::DW'(dprod >>> lre_pkg::Q15);
  end
endmodule : lre_adaptive_pulse_quantizer_quant

/* File: logic/ltp_rpe_subframe_encoder.sv */
// Long term predictor and regular pulse excitation encoder for one sub-segment
`timescale 1ns/1ps
module ltp_rpe_subframe_encoder (
  input  wire logic              REF_CLK,         // 20 MHz clock
  input  wire logic              NRST,            // Sync reset, active low
  input  wire logic              D_VALID,         // Residual sample offered
  input  wire logic [15:0]       D_DATA,          // Short term residual sample
  output logic                   D_READY,         // Sample accepted when high
  output logic                   SUB_VALID,       // Parameter set pulse
  output logic [1:0]             SUB_INDEX,       // Sub-segment within frame
  output logic [6:0]             LAG_CODE,        // Lag, plain binary
  output logic [1:0]             GAIN_CODE,       // Gain code
  output logic [1:0]             GRID_INDEX_CODE, // Chosen grid
  output logic [5:0]             BLOCK_MAX_CODE,  // Log block maximum
  output logic [38:0]            PULSE_CODES      // Pulse i at bits 3i+2:3i
);
  localparam int DW = lre_pkg::DW;
  localparam int AW = lre_pkg::ACC_W;
  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  lre_pkg::lre_state_e   state_r;                     // Sequencer
  logic signed [DW-1:0]  cur_r  [lre_pkg::SUB_LEN];   // Input, later d'
  logic signed [DW-1:0]  hist_r [lre_pkg::HIST_LEN];  // Reconstructed history
  logic signed [DW-1:0]  p_r    [lre_pkg::SUB_LEN];   // Prediction
  logic signed [DW-1:0]  e_r    [lre_pkg::SUB_LEN];   // Long term residual
  logic signed [DW-1:0]  x_r    [lre_pkg::SUB_LEN];   // Weighted residual
  logic signed [DW-1:0]  dq_r   [lre_pkg::PULSES];    // Decoded pulses
  logic [2:0]            pls_r  [lre_pkg::PULSES];    // Pulse codes
  logic [6:0]            k_r;                         // Sample/pulse index
  logic [6:0]            lag_r;                       // Lag under test
  logic [6:0]            best_lag_r;                  // Peak lag
  logic [3:0]            tap_r;                       // Filter tap
  logic [1:0]            m_r;                         // Grid under test
  logic [1:0]            grid_r;                      // Best grid
  logic [1:0]            gcode_r;                     // Gain code
  logic [1:0]            sub_r;                       // Sub-segment count
  logic signed [AW-1:0]  acc_r;                       // Running sum
  logic signed [AW-1:0]  best_r;                      // Peak correlation / energy
  logic signed [AW-1:0]  ener_r;                      // Lagged energy
  logic [DW-1:0]         xmax_r;                      // Block maximum
  // Combinational helpers
  logic                  take;                        // Sample handshake
  logic                  last_k;                      // Last sample of sub-segment
  logic [6:0]            hidx;                        // History index
  logic signed [DW-1:0]  hs;                          // History sample
  logic signed [AW-1:0]  corr_fin, ener_fin;          // Closing sums
  logic signed [AW-1:0]  pprod;                       // Gain times history
  logic signed [DW-1:0]  p_c, e_c;                    // Prediction, residual
  logic signed [7:0]     widx;                        // Filter input index
  logic signed [AW-1:0]  w_fin;                       // Filter sum
  logic [5:0]            gidx, qidx;                  // Grid sample indices
  logic signed [AW-1:0]  g_fin;                       // Grid energy sum
  logic signed [DW-1:0]  qs;                          // Selected pulse sample
  logic [DW:0]           qabs;                        // Magnitude, one bit wider
  logic [DW-1:0]         qmag;                        // Clamped magnitude
  logic [6:0]            off;                         // Offset from grid start
  logic signed [DW-1:0]  ep;                          // Decoded residual sample
  logic signed [DW-1:0]  d_c;                         // Rebuilt history sample
  logic [1:0]            gsel;                        // Gain decision
  logic [5:0]            xmaxc;                       // From quantiser
  logic [DW-1:0]         xmaxp;
  logic [2:0]            pcode;
  logic signed [DW-1:0]  pdec;

  // ----------------------------------------------------------------
  // Datapath terms
  // ----------------------------------------------------------------
  assign take   = D_VALID && D_READY;
  assign last_k = (k_r == 7'(lre_pkg::SUB_LEN - 1));
  // History sample d'(k - lag); lag is 40..120 so index stays 0..119
  assign hidx = 7'(lre_pkg::HIST_LEN + int'(k_r) - int'((state_r == lre_pkg::ST_CORR) ? lag_r : best_lag_r));
  assign hs   = hist_r[hidx];
  assign corr_fin = acc_r + AW'(cur_r[k_r[5:0]] * hs);
  assign ener_fin = acc_r + AW'(hs * hs);
  assign pprod = AW'(lre_pkg::QLB_TAB[gcode_r] * hs);
  assign p_c   = DW'(pprod >>> lre_pkg::Q15);
  assign e_c   = lre_pkg::lre_sat(AW'(cur_r[k_r[5:0]]) - AW'(p_c));
  // Block filter: inputs outside the sub-segment count as zero
  assign widx  = 8'(int'(k_r) + lre_pkg::TAP_MID - int'(tap_r));
  assign w_fin = acc_r + ((widx >= 0 && widx < 8'(lre_pkg::SUB_LEN))
               ? AW'(lre_pkg::H_TAB[tap_r] * e_r[widx[5:0]]) : '0);
  assign gidx  = 6'(int'(m_r) + lre_pkg::DECIM * int'(k_r));
  assign g_fin = acc_r + AW'(x_r[gidx] * x_r[gidx]);
  assign qidx  = 6'(int'(grid_r) + lre_pkg::DECIM * int'(k_r));
  assign qs    = x_r[qidx];
  assign qabs  = qs[DW-1] ? (DW+1)'(-$signed({qs[DW-1], qs})) : {1'b0, qs};
  // The table stops at 32767, so a full-scale negative sample is clamped
  assign qmag  = (qabs > (DW+1)'(lre_pkg::XM_TOP)) ? DW'(lre_pkg::XM_TOP) : qabs[DW-1:0];
  assign off   = k_r - 7'(grid_r);
  // Grid 0 also lands on sample 39, which lies past the last pulse: keep it zero
  assign ep    = (k_r >= 7'(grid_r) && off < 7'(lre_pkg::DECIM * lre_pkg::PULSES)
                 && (off % 7'(lre_pkg::DECIM)) == 7'h00)
               ? dq_r[4'(off / 7'(lre_pkg::DECIM))] : '0;
  assign d_c   = lre_pkg::lre_sat(AW'(ep) + AW'(p_r[k_r[5:0]]));

  // Gain: b <= GAIN_DECISION_LEVEL(i) tested as 10*R <= n(i)*S, lowest code wins
  always_comb begin
    gsel = 2'h3;
    for (int i = 2; i >= 0; i--) begin
      if (best_r * lre_pkg::GDL_DEN <= ener_r * lre_pkg::GDL_NUM[i]) begin
        gsel = 2'(i);
      end
    end
  end

  lre_adaptive_pulse_quantizer_quant u_quant (
    .xmax  (xmax_r),
    .smp   (qs),
    .xmaxc (xmaxc),
    .xmaxp (xmaxp),
    .pcode (pcode),
    .pdec  (pdec)
  );

  // ----------------------------------------------------------------
  // Sequencer and counters
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state_r <= lre_pkg::ST_LOAD;
      k_r     <= '0;
      lag_r   <= 7'(lre_pkg::LAG_MIN);
      tap_r   <= '0;
      m_r     <= '0;
      D_READY <= 1'b1;
    end else begin
      case (state_r)
        lre_pkg::ST_LOAD: if (take) begin
          k_r <= last_k ? '0 : k_r + 7'h01;
          if (last_k) begin
            D_READY <= 1'b0;
            lag_r   <= 7'(lre_pkg::LAG_MIN);
            state_r <= lre_pkg::ST_CORR;
          end
        end
        lre_pkg::ST_CORR: begin
          k_r <= last_k ? '0 : k_r + 7'h01;
          if (last_k) begin
            lag_r <= lag_r + 7'h01;
            if (lag_r == 7'(lre_pkg::LAG_MAX)) state_r <= lre_pkg::ST_ENER;
          end
        end
        lre_pkg::ST_ENER: begin
          k_r <= last_k ? '0 : k_r + 7'h01;
          if (last_k) state_r <= lre_pkg::ST_GAIN;
        end
        lre_pkg::ST_GAIN: state_r <= lre_pkg::ST_PRED;
        lre_pkg::ST_PRED: begin
          k_r <= last_k ? '0 : k_r + 7'h01;
          if (last_k) state_r <= lre_pkg::ST_WGT;
        end
        lre_pkg::ST_WGT: begin
          tap_r <= (tap_r == 4'(lre_pkg::TAPS - 1)) ? '0 : tap_r + 4'h1;
          if (tap_r == 4'(lre_pkg::TAPS - 1)) begin
            k_r <= last_k ? '0 : k_r + 7'h01;
            if (last_k) state_r <= lre_pkg::ST_GRID;
          end
        end
        lre_pkg::ST_GRID: begin
          k_r <= (k_r == 7'(lre_pkg::PULSES - 1)) ? '0 : k_r + 7'h01;
          if (k_r == 7'(lre_pkg::PULSES - 1)) begin
            m_r <= m_r + 2'h1;
            if (m_r == 2'(lre_pkg::GRIDS - 1)) state_r <= lre_pkg::ST_XMAX;
          end
        end
        lre_pkg::ST_XMAX, lre_pkg::ST_QNT: begin
          k_r <= (k_r == 7'(lre_pkg::PULSES - 1)) ? '0 : k_r + 7'h01;
          if (k_r == 7'(lre_pkg::PULSES - 1)) begin
            state_r <= (state_r == lre_pkg::ST_XMAX) ? lre_pkg::ST_QNT : lre_pkg::ST_REC;
          end
        end
        lre_pkg::ST_REC: begin
          k_r <= last_k ? '0 : k_r + 7'h01;
          if (last_k) state_r <= lre_pkg::ST_OUT;
        end
        lre_pkg::ST_OUT: begin
          D_READY <= 1'b1;
          state_r <= lre_pkg::ST_LOAD;
        end
        default: state_r <= lre_pkg::ST_LOAD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulators and searches
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      acc_r      <= '0;
      best_r     <= '0;
      ener_r     <= '0;
      best_lag_r <= 7'(lre_pkg::LAG_MIN);
      grid_r     <= '0;
      gcode_r    <= '0;
      xmax_r     <= '0;
    end else begin
      case (state_r)
        lre_pkg::ST_CORR: begin
          acc_r <= last_k ? '0 : corr_fin;
          // Strict compare keeps the lowest lag on a tie
          if (last_k && (lag_r == 7'(lre_pkg::LAG_MIN) || corr_fin > best_r)) begin
            best_r     <= corr_fin;
            best_lag_r <= lag_r;
          end
        end
        lre_pkg::ST_ENER: begin
          acc_r <= last_k ? '0 : ener_fin;
          if (last_k) ener_r <= ener_fin;
        end
        lre_pkg::ST_GAIN: gcode_r <= gsel;
        lre_pkg::ST_WGT: acc_r <= (tap_r == 4'(lre_pkg::TAPS - 1)) ? '0 : w_fin;
        lre_pkg::ST_GRID: begin
          acc_r <= (k_r == 7'(lre_pkg::PULSES - 1)) ? '0 : g_fin;
          if (k_r == 7'(lre_pkg::PULSES - 1) && (m_r == 2'h0 || g_fin > best_r)) begin
            best_r <= g_fin;
            grid_r <= m_r;
          end
        end
        lre_pkg::ST_XMAX: begin
          if (k_r == 7'h00 || qmag > xmax_r) xmax_r <= qmag;
        end
        default: acc_r <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample arrays; history starts from silence
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      for (int i = 0; i < lre_pkg::HIST_LEN; i++) hist_r[i] <= '0;
    end else begin
      case (state_r)
        lre_pkg::ST_LOAD: if (take) cur_r[k_r[5:0]] <= $signed(D_DATA);
        lre_pkg::ST_PRED: begin
          p_r[k_r[5:0]] <= p_c;
          e_r[k_r[5:0]] <= e_c;
        end
        lre_pkg::ST_WGT: begin
          if (tap_r == 4'(lre_pkg::TAPS - 1)) x_r[k_r[5:0]] <= lre_pkg::lre_sat(w_fin >>> lre_pkg::H_SHIFT);
        end
        lre_pkg::ST_QNT: begin
          pls_r[k_r[3:0]] <= pcode;
          dq_r[k_r[3:0]]  <= pdec;
        end
        lre_pkg::ST_REC: cur_r[k_r[5:0]] <= d_c;
        lre_pkg::ST_OUT: begin
          // Slide history by one sub-segment, newest at the top
          for (int i = 0; i < lre_pkg::HIST_LEN; i++) begin
            hist_r[i] <= (i < lre_pkg::HIST_LEN - lre_pkg::SUB_LEN) ? hist_r[(i + lre_pkg::SUB_LEN) % lre_pkg::HIST_LEN]
                       : cur_r[(i + lre_pkg::SUB_LEN) % lre_pkg::SUB_LEN];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      SUB_VALID       <= 1'b0;
      sub_r           <= '0;
      SUB_INDEX       <= 2'h3;  // Reads one before the first set
      LAG_CODE        <= '0;
      GAIN_CODE       <= '0;
      GRID_INDEX_CODE <= '0;
      BLOCK_MAX_CODE  <= '0;
      PULSE_CODES     <= '0;
    end else begin
      SUB_VALID <= (state_r == lre_pkg::ST_OUT);
      if (state_r == lre_pkg::ST_OUT) begin
        sub_r           <= sub_r + 2'h1;
        SUB_INDEX       <= sub_r;
        LAG_CODE        <= best_lag_r;
        GAIN_CODE       <= gcode_r;
        GRID_INDEX_CODE <= grid_r;
        BLOCK_MAX_CODE  <= xmaxc;
        for (int i = 0; i < lre_pkg::PULSES; i++) PULSE_CODES[lre_pkg::PCODE_W*i +: lre_pkg::PCODE_W] <= pls_r[i];
      end
    end
  end

  // Filter pass length; too long for a plain delay in a property
  logic [8:0]            wgt_cnt_r;                   // Cycles spent filtering
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      wgt_cnt_r <= '0;
    end else if (state_r == lre_pkg::ST_WGT) begin
      wgt_cnt_r <= wgt_cnt_r + 9'h001;
    end else begin
      wgt_cnt_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_lag_range: assert property (
    SUB_VALID |-> (LAG_CODE >= 7'(lre_pkg::LAG_MIN) && LAG_CODE <= 7'(lre_pkg::LAG_MAX)))
    else $error("lag outside search range");
  a_hist_clear: assert property (disable iff (1'b0)
    !NRST |=> (hist_r[0] == '0 && hist_r[lre_pkg::HIST_LEN - 1] == '0))
    else $error("history not cleared by reset");
  a_load_close: assert property (
    (state_r == lre_pkg::ST_LOAD && take && last_k) |=> (state_r == lre_pkg::ST_CORR && !D_READY))
    else $error("sub-segment not closed after 40 samples");
  a_corr_span: assert property (
    (state_r == lre_pkg::ST_CORR && lag_r == 7'(lre_pkg::LAG_MAX) && last_k) |=> state_r == lre_pkg::ST_ENER)
    else $error("lag search did not end at longest lag");
  a_tie_low: assert property (
    (state_r == lre_pkg::ST_CORR && last_k && lag_r != 7'(lre_pkg::LAG_MIN) && corr_fin <= best_r)
    |=> $stable(best_lag_r)) else $error("tie moved the chosen lag");
  a_gain_low: assert property (
    (state_r == lre_pkg::ST_GAIN && best_r <= 0) |=> gcode_r == 2'h0)
    else $error("non-positive gain not coded zero");
  a_wgt_len: assert property (
    (state_r != lre_pkg::ST_WGT && wgt_cnt_r != 9'h000)
    |-> (state_r == lre_pkg::ST_GRID && wgt_cnt_r == 9'(lre_pkg::TAPS * lre_pkg::SUB_LEN)))
    else $error("filter pass length wrong");
  a_pulse_sign: assert property (
    (state_r == lre_pkg::ST_QNT && qs >= 0) |-> pcode >= 3'(lre_pkg::PLS_MID))
    else $error("non-negative pulse coded negative");
  a_xmax_bound: assert property (
    state_r == lre_pkg::ST_QNT |-> (xmaxp >= xmax_r && qmag <= xmaxp))
    else $error("decoded maximum below a pulse");
  a_out_once: assert property (
    SUB_VALID |-> ($past(state_r) == lre_pkg::ST_OUT && D_READY))
    else $error("parameter pulse out of place");

  c_sub_done:   cover property (SUB_VALID);
  c_frame_end:  cover property (SUB_VALID && SUB_INDEX == 2'h3);
  c_gain_top:   cover property (SUB_VALID && GAIN_CODE == 2'h3);
  c_grid_other: cover property (SUB_VALID && GRID_INDEX_CODE != 2'h0);
endmodule : ltp_rpe_subframe_encoder

/* File: tb/lre_res_src.sv */
// Upstream residual source model
`timescale 1ns/1ps
module lre_res_src (
  input  wire logic        clk,     // Bench clock
  input  wire logic        d_ready, // Encoder takes sample
  output logic             d_valid, // Sample offered
  output logic signed [15:0] d_data // Residual sample
);
  initial begin
    d_valid = 1'b0;
    d_data  = 16'h0000;
  end
  // One sub-segment, random idle gaps; released data toggles so stale values never match
  task automatic send(input logic signed [15:0] s [40], input int gmax);
    for (int k = 0; k < 40; k++) begin
      repeat ($urandom % (gmax + 1)) begin
        @(negedge clk);
        d_valid = 1'b0;
        d_data  = ~d_data;
      end
      @(negedge clk);
      d_valid = 1'b1;
      d_data  = s[k];
      // Held until ready seen
      while (d_ready !== 1'b1) @(negedge clk);
    end
    @(negedge clk);
    d_valid = 1'b0;
    d_data  = ~d_data;
  endtask : send
endmodule : lre_res_src

/* File: tb/test_ltp_rpe_subframe_encoder.sv */
// Self-checking bench for the sub-segment encoder
`timescale 1ns/1ps
module test_ltp_rpe_subframe_encoder;
  logic REF_CLK, NRST, D_VALID, D_READY, SUB_VALID;
  logic [15:0] D_DATA;
  logic [1:0]  SUB_INDEX, GAIN_CODE, GRID_INDEX_CODE, si;
  logic [6:0]  LAG_CODE;
  logic [5:0]  BLOCK_MAX_CODE;
  logic [38:0] PULSE_CODES, pc_x;
  int          bad_count, checked, lag_x, gain_x, grid_x, xc_x;
  longint      hist [120]; // Model history, oldest first
  logic signed [15:0] d [40];
  ltp_rpe_subframe_encoder ltp_rpe_subframe_encoder_i (.REF_CLK(REF_CLK), .NRST(NRST), .D_VALID(D_VALID),
    .D_DATA(D_DATA), .D_READY(D_READY), .SUB_VALID(SUB_VALID), .SUB_INDEX(SUB_INDEX), .LAG_CODE(LAG_CODE),
    .GAIN_CODE(GAIN_CODE), .GRID_INDEX_CODE(GRID_INDEX_CODE), .BLOCK_MAX_CODE(BLOCK_MAX_CODE),
    .PULSE_CODES(PULSE_CODES));
  lre_res_src lre_res_src_i (.clk(REF_CLK), .d_ready(D_READY), .d_valid(D_VALID), .d_data(D_DATA));
  function automatic longint sat(input longint v);
    return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
  endfunction : sat
  // Upper edge of a block maximum interval
  function automatic longint xup(input int c);
    return (c < 16) ? 32 * c + 31 : (longint'(c % 8 + 9) << (c / 8 + 4)) - 1;
  endfunction : xup
  task automatic chk(input string w, input logic [63:0] x, input logic [63:0] g);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", w, x, g);
    end
  endtask : chk
  // Reference for one sub-segment; also advances history
  task automatic model();
    longint r, br, s, e[40], x[40], pr[40], dp[40], en, be, xm, xq;
    int q;
    br = 64'sh8000000000000000;
    for (int l = 40; l <= 120; l++) begin
      r = 0;
      for (int i = 0; i < 40; i++) r += d[i] * hist[120 + i - l];
      lag_x = (r > br) ? l : lag_x;
      br = (r > br) ? r : br;
    end
    s = 0;
    for (int i = 0; i < 40; i++) s += hist[120 + i - lag_x] * hist[120 + i - lag_x];
    gain_x = 3;
    for (int k = 2; k >= 0; k--) if (10 * br <= lre_pkg::GDL_NUM[k] * s) gain_x = k;
    for (int i = 0; i < 40; i++) begin
      pr[i] = (longint'(lre_pkg::QLB_TAB[gain_x]) * hist[120 + i - lag_x]) >>> 15;
      e[i] = sat(d[i] - pr[i]);
      dp[i] = 0;
    end
    for (int k = 0; k < 40; k++) begin
      x[k] = 0;
      for (int i = 0; i < 11; i++) if (k + 5 - i >= 0 && k + 5 - i < 40) x[k] += lre_pkg::H_TAB[i] * e[k + 5 - i];
      x[k] = sat(x[k] >>> 13);
    end
    be = -1;
    xm = 0;
    for (int m = 0; m < 4; m++) begin
      en = 0;
      for (int i = 0; i < 13; i++) en += x[m + 3 * i] * x[m + 3 * i];
      grid_x = (en > be) ? m : grid_x;
      be = (en > be) ? en : be;
    end
    for (int i = 0; i < 13; i++) xm = (x[grid_x + 3 * i] * x[grid_x + 3 * i] > xm * xm) ? x[grid_x + 3 * i] : xm;
    xm = sat((xm < 0) ? -xm : xm);
    xc_x = 0;
    while (xup(xc_x) < xm) xc_x++;
    xq = xup(xc_x);
    for (int i = 0; i < 13; i++) begin
      q = 0;
      for (int t = 1; t < 8; t++) q = (4 * x[grid_x + 3 * i] >= (t - 4) * xq) ? t : q;
      pc_x[3 * i +: 3] = 3'(q);
      dp[grid_x + 3 * i] = ((lre_pkg::PLS_BASE + lre_pkg::PLS_STEP * q) * xq) >>> 15;
    end
    for (int i = 0; i < 80; i++) hist[i] = hist[i + 40];
    for (int i = 0; i < 40; i++) hist[80 + i] = sat(dp[i] + pr[i]);
  endtask : model
  task automatic do_reset();
    @(negedge REF_CLK);
    NRST = 1'b0;
    repeat (2) @(negedge REF_CLK);
    chk("rst", 64'h2, {D_READY, SUB_VALID});
    chk("rst codes", 64'h0, {LAG_CODE, GAIN_CODE, GRID_INDEX_CODE, BLOCK_MAX_CODE, PULSE_CODES});
    chk("rst index", 64'h3, SUB_INDEX);
    NRST = 1'b1;
    foreach (hist[i]) hist[i] = 0;
    si = 2'h0;
  endtask : do_reset
  task automatic run_sub();
    int n;
    model();
    lre_res_src_i.send(d, 2);
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
      if (n == 1) chk("busy", 64'h0, D_READY);
    end while (SUB_VALID !== 1'b1 && n < 5000);
    chk("latency", 64'd3880, 64'(n));
    chk("lag", 64'(lag_x), LAG_CODE);
    chk("gain", 64'(gain_x), GAIN_CODE);
    chk("grid", 64'(grid_x), GRID_INDEX_CODE);
    chk("xmax", 64'(xc_x), BLOCK_MAX_CODE);
    chk("pulses", 64'(pc_x), PULSE_CODES);
    chk("index", 64'(si), SUB_INDEX);
    @(negedge REF_CLK);
    chk("strobe", 64'h1, {SUB_VALID, D_READY});
    si++;
  endtask : run_sub
  task automatic stop_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  // Watchdog well beyond ten sub-segments
  initial begin
    repeat (60000) @(posedge REF_CLK);
    bad_count++;
    stop_test();
  end
  // Zero, impulse, random, repeat, full-scale, then mid-run reset
  initial begin
    NRST = 1'b0;
    void'($urandom(34));
    do_reset();
    for (int t = 0; t < 10; t++) begin
      if (t == 8) do_reset();
      for (int k = 0; k < 40; k++) begin
        if (t == 0) d[k] = 16'h0000;
        else if (t == 1) d[k] = (k == 18) ? 16'h4E20 : 16'h0000;
        else if (t == 6) d[k] = k[0] ? 16'h8000 : 16'h7FFF;
        else if (t != 3) d[k] = $signed(16'($urandom)) >>> ($urandom % 6);
      end
      run_sub();
    end
    stop_test();
  end
endmodule : test_ltp_rpe_subframe_encoder
